// >>> hdl/daq_card_host_register_file.v
// Byte-wide host register file of a multi-channel analog output card
`timescale 1ns/1ps
`include "daq_card_map.vh"

module daq_card_host_register_file #(
    parameter IDENT_PRESENT = 1
) (
    input wire clk_sys,
    input wire rst,
    input wire [7:0] io_addr,
    input wire io_wr,
    input wire io_rd,
    input wire [7:0] io_wdata,
    output reg [7:0] io_rdata,
    input wire irq_source_0,
    input wire irq_source_1,
    output reg irq_sel_0,
    output reg irq_sel_1,
    input wire [3:0] board_ident,
    input wire [15:0] in_line,
    output reg [15:0] out_line,
    output reg dio_enable,
    output reg [13:0] analog_word,
    output reg [3:0] analog_channel,
    output reg conv_start,
    output reg [17:0] timer_cfg,
    output reg [2:0] timer_cfg_wr,
    output reg [47:0] timer_reload,
    output reg [2:0] timer_load,
    input wire [47:0] timer_count
);

    // ************************************************************
    // Local state
    // ************************************************************
    // Interrupt routing and analog staging
    reg [1:0] polarity;
    reg [7:0] analog_low_buf;
    reg [7:0] analog_high_buf;
    // Per-counter byte phase and latch state
    reg [2:0] wr_high_next;
    reg [2:0] rd_high_next;
    reg [2:0] latched;
    reg [47:0] latch_val;
    // Read path and loop index
    reg [7:0] next_rdata;
    integer i;

    // ************************************************************
    // Helper functions
    // ************************************************************
    // Counter index from a data port offset (c0, c4, c8)
    // The index falls out of address bits 3:2, so no comparator is needed
    function [1:0] cnt_index;
        input [7:0] addr;
        begin
            cnt_index = addr[3:2];
        end
    endfunction

    // Access field of one counter's stored configuration
    function [1:0] cfg_access;
        input [17:0] cfg;
        input [1:0] idx;
        begin
            cfg_access = cfg[idx * 6 + 4 +: 2];
        end
    endfunction

    // Byte of the value the host sees when reading a counter
    function [7:0] cnt_byte;
        input [15:0] value;
        input [1:0] acc;
        input hi_phase;
        begin
            if (acc == `ACC_HIGH_ONLY || (acc == `ACC_LOW_HIGH && hi_phase)) begin
                cnt_byte = value[15:8];
            end else begin
                cnt_byte = value[7:0];
            end
        end
    endfunction

    // ************************************************************
    // Access decode
    // ************************************************************
    // Used by the timer process; wr_idx and cur_acc are shared with the read mux
    wire [1:0] wr_idx = cnt_index(io_addr);
    wire [1:0] tcw_sel = io_wdata[`TCW_SEL_MSB:`TCW_SEL_LSB];
    wire [1:0] tcw_acc = io_wdata[`TCW_ACC_MSB:`TCW_ACC_LSB];
    wire is_cnt_port = (io_addr == `OFS_TIMER_CNT0) || (io_addr == `OFS_TIMER_CNT1) ||
        (io_addr == `OFS_TIMER_CNT2);
    wire [1:0] cur_acc = cfg_access(timer_cfg, wr_idx);

    // ************************************************************
    // Read data multiplexer
    // ************************************************************
    // Unmapped and write-only offsets read as zero
    always @* begin
        next_rdata = `RST_RDATA;
        case (io_addr)
            `OFS_IRQ_POLARITY: begin
                next_rdata = {6'h00, polarity};
            end
            `OFS_TIMER_CNT0, `OFS_TIMER_CNT1, `OFS_TIMER_CNT2: begin
                next_rdata = cnt_byte(latched[wr_idx] ? latch_val[wr_idx * 16 +: 16] :
                    timer_count[wr_idx * 16 +: 16], cur_acc, rd_high_next[wr_idx]);
            end
            `OFS_TIMER_CTRL: begin
                next_rdata = 8'h00; // Control word reads back as zero
            end
            `OFS_BOARD_IDENT: begin
                next_rdata = IDENT_PRESENT ? {4'h0, board_ident} : 8'h00;
            end
            `OFS_DIN_LOW: begin
                next_rdata = dio_enable ? in_line[7:0] : 8'h00;
            end
            `OFS_DIN_HIGH: begin
                next_rdata = dio_enable ? in_line[15:8] : 8'h00;
            end
            default: begin
                next_rdata = `RST_RDATA;
            end
        endcase
    end

    // ************************************************************
    // Interrupt source polarity
    // ************************************************************
    // Registered so the routed levels come straight from flops
    // One cycle of delay buys a glitch-free routed level
    always @(posedge clk_sys) begin
        if (rst) begin
            irq_sel_0 <= 1'b0;
            irq_sel_1 <= 1'b0;
        end else begin
            irq_sel_0 <= polarity[0] ? irq_source_0 : ~irq_source_0;
            irq_sel_1 <= polarity[1] ? irq_source_1 : ~irq_source_1;
        end
    end

    // ************************************************************
    // Host writes: control, digital, analog
    // ************************************************************
    // Read data is presented one cycle after the read strobe
    always @(posedge clk_sys) begin
        if (rst) begin
            io_rdata <= `RST_RDATA;
            polarity <= `RST_POLARITY;
            dio_enable <= 1'b0;
            out_line <= 16'h0000;
            analog_low_buf <= 8'h00;
            analog_high_buf <= 8'h00;
            analog_word <= 14'h0000;
            analog_channel <= 4'h0;
            conv_start <= 1'b0;
        end else begin
            conv_start <= 1'b0;
            // Read data moves only on a read strobe, so it holds between reads
            if (io_rd) begin
                io_rdata <= next_rdata;
            end
            // Outputs clear one cycle after disable, then sit at zero; writes then are dropped, not queued
            if (!dio_enable) begin
                out_line <= 16'h0000;
            end
            if (io_wr) begin
                case (io_addr)
                    `OFS_RESET_CTRL: begin
                        dio_enable <= io_wdata[`DIO_ENABLE_BIT];
                    end
                    `OFS_IRQ_POLARITY: begin
                        polarity <= io_wdata[1:0];
                    end
                    `OFS_DOUT_LOW: begin
                        if (dio_enable) begin
                            out_line[7:0] <= io_wdata;
                        end
                    end
                    `OFS_DOUT_HIGH: begin
                        if (dio_enable) begin
                            out_line[15:8] <= io_wdata;
                        end
                    end
                    // Staging only; nothing reaches the converter before a select write
                    `OFS_ANALOG_LOW: begin
                        analog_low_buf <= io_wdata;
                    end
                    `OFS_ANALOG_HIGH: begin
                        analog_high_buf <= io_wdata;
                    end
                    // Host is trusted to have loaded both data bytes first
                    `OFS_CONV_SEL0, `OFS_CONV_SEL1, `OFS_CONV_SEL2, `OFS_CONV_SEL3: begin
                        analog_word <= {analog_high_buf[5:0], analog_low_buf};
                        analog_channel <= {io_addr[3:2],
                            analog_high_buf[`ANALOG_CHAN_MSB:`ANALOG_CHAN_LSB]};
                        conv_start <= 1'b1;
                    end
                    default: begin
                        conv_start <= 1'b0;
                    end
                endcase
            end
        end
    end

    // ************************************************************
    // Timer register interface
    // ************************************************************
    // Count values come from the counter core; only programming and latching live here.
    // A control word write that programs a counter (not latch, not read-back) restarts the low/high byte sequence of that counter.
    always @(posedge clk_sys) begin
        if (rst) begin
            timer_cfg <= `RST_TIMER_CFG;
            timer_cfg_wr <= 3'h0;
            timer_reload <= 48'h000000000000;
            timer_load <= 3'h0;
            wr_high_next <= 3'h0;
            rd_high_next <= 3'h0;
            latched <= 3'h0;
            latch_val <= 48'h000000000000;
        end else begin
            timer_cfg_wr <= 3'h0;
            timer_load <= 3'h0;
            // Select code 11 is read-back and never overwrites a counter's setup
            if (io_wr && io_addr == `OFS_TIMER_CTRL) begin
                if (tcw_sel == `TCW_SEL_READBACK) begin
                    // Read-back with the count bit (bit 5) clear: latch every selected counter not already latched
                    for (i = 0; i < 3; i = i + 1) begin
                        if (io_wdata[1 + i] && !io_wdata[`TCW_RB_NOCOUNT_BIT] && !latched[i]) begin
                            latched[i] <= 1'b1;
                            latch_val[i * 16 +: 16] <= timer_count[i * 16 +: 16];
                        end
                    end
                end else if (tcw_acc == `ACC_LATCH) begin
                    // Freeze the count until the host has read it out
                    if (!latched[tcw_sel]) begin
                        latched[tcw_sel] <= 1'b1;
                        latch_val[tcw_sel * 16 +: 16] <= timer_count[tcw_sel * 16 +: 16];
                    end
                end else begin
                    // Access, mode and BCD bits stored per counter
                    timer_cfg[tcw_sel * 6 +: 6] <= io_wdata[5:0];
                    timer_cfg_wr[tcw_sel] <= 1'b1;
                    wr_high_next[tcw_sel] <= 1'b0;
                    rd_high_next[tcw_sel] <= 1'b0;
                    latched[tcw_sel] <= 1'b0;
                end
            end
            // Counter data bytes follow the access format stored for that counter
            if (io_wr && is_cnt_port) begin
                case (cur_acc)
                    `ACC_LOW_ONLY: begin
                        timer_reload[wr_idx * 16 +: 8] <= io_wdata;
                        timer_load[wr_idx] <= 1'b1;
                    end
                    `ACC_HIGH_ONLY: begin
                        timer_reload[wr_idx * 16 + 8 +: 8] <= io_wdata;
                        timer_load[wr_idx] <= 1'b1;
                    end
                    `ACC_LOW_HIGH: begin
                        if (wr_high_next[wr_idx]) begin
                            timer_reload[wr_idx * 16 + 8 +: 8] <= io_wdata;
                            timer_load[wr_idx] <= 1'b1;
                        end else begin
                            timer_reload[wr_idx * 16 +: 8] <= io_wdata;
                        end
                        wr_high_next[wr_idx] <= ~wr_high_next[wr_idx];
                    end
                    default: begin
                        timer_load[wr_idx] <= 1'b0;
                    end
                endcase
            end
            // A complete read of a latched value releases the latch
            if (io_rd && is_cnt_port) begin
                if (cur_acc == `ACC_LOW_HIGH) begin
                    rd_high_next[wr_idx] <= ~rd_high_next[wr_idx];
                    if (rd_high_next[wr_idx]) begin
                        latched[wr_idx] <= 1'b0;
                    end
                end else begin
                    latched[wr_idx] <= 1'b0;
                end
            end
        end
    end

endmodule // daq_card_host_register_file

// >>> hdl/daq_card_map.vh
// Register offsets, field positions and reset values of the host register file
`ifndef DAQ_CARD_MAP_VH
`define DAQ_CARD_MAP_VH

// ************************************************************
// Byte offsets within the card's I/O window
// ************************************************************
`define OFS_RESET_CTRL 8'h00
`define OFS_IRQ_POLARITY 8'h2a
`define OFS_TIMER_CNT0 8'hc0
`define OFS_TIMER_CNT1 8'hc4
`define OFS_TIMER_CNT2 8'hc8
`define OFS_TIMER_CTRL 8'hcc
`define OFS_BOARD_IDENT 8'hd4
`define OFS_DIN_LOW 8'he0
`define OFS_DIN_HIGH 8'he4
`define OFS_CONV_SEL0 8'he0
`define OFS_CONV_SEL1 8'he4
`define OFS_CONV_SEL2 8'he8
`define OFS_CONV_SEL3 8'hec
`define OFS_ANALOG_LOW 8'hf0
`define OFS_ANALOG_HIGH 8'hf4
`define OFS_DOUT_LOW 8'hf8
`define OFS_DOUT_HIGH 8'hfc

// ************************************************************
// Timer control word fields
// ************************************************************
`define TCW_SEL_MSB 7
`define TCW_SEL_LSB 6
`define TCW_ACC_MSB 5
`define TCW_ACC_LSB 4
`define TCW_MODE_MSB 3
`define TCW_MODE_LSB 1
`define TCW_BCD_BIT 0
`define TCW_SEL_READBACK 2'h3
`define TCW_RB_NOCOUNT_BIT 5
`define ACC_LATCH 2'h0
`define ACC_LOW_ONLY 2'h1
`define ACC_HIGH_ONLY 2'h2
`define ACC_LOW_HIGH 2'h3
`define MODE_TERM_COUNT 3'h0
`define MODE_ONE_SHOT 3'h1
`define MODE_RATE_GEN 3'h2
`define MODE_SQUARE 3'h3
`define MODE_SW_STROBE 3'h4
`define MODE_HW_STROBE 3'h5

// ************************************************************
// Other fields and reset values
// ************************************************************
`define DIO_ENABLE_BIT 0
`define ANALOG_CHAN_MSB 7
`define ANALOG_CHAN_LSB 6
`define RST_POLARITY 2'h0
`define RST_TIMER_CFG 18'h00000
`define RST_RDATA 8'h00

`endif

// >>> verif/daq_card_host_register_file_tb_top.sv
// Self-checking bench for the host register file
`timescale 1ns/1ps
module daq_card_host_register_file_tb_top;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    wire [7:0] io_addr, io_wdata, io_rdata;
    wire io_wr, io_rd, irq_sel_0, irq_sel_1, dio_enable, conv_start;
    logic irq_source_0 = 1'b0;
    logic irq_source_1 = 1'b0;
    logic [3:0] board_ident = 4'hb;
    logic [15:0] in_line = 16'h5aa5;
    logic [47:0] timer_count = 48'h3456_789a_bcde;
    wire [15:0] out_line;
    wire [13:0] analog_word;
    wire [3:0] analog_channel;
    wire [17:0] timer_cfg;
    wire [2:0] timer_cfg_wr, timer_load;
    wire [47:0] timer_reload;
    int errors = 0;
    int n_tests = 0;
    logic [7:0] d;
    logic [1:0] n, ch;
    logic [13:0] val, prev_val;

    daq_card_host_register_file i_dut (.*);
    host_bus_model i_host (.*);

    // 25 MHz system clock
    always #20 clk_sys = ~clk_sys;

    // ************************************************************
    // Checking and closing
    // ************************************************************
    task chk(input string name, input logic [47:0] exp, input logic [47:0] got);
        n_tests++;
        if (got !== exp) begin
            errors++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask

    task tally_and_finish;
        $display("Comparisons %0d mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask

    // Watchdog well beyond the hundred or so cycles the sequence needs
    initial begin
        #200000;
        errors++;
        tally_and_finish;
    end

    // ************************************************************
    // Main sequence
    // ************************************************************
    initial begin
        repeat (8) @(posedge clk_sys);
        @(negedge clk_sys);
        rst = 1'b0;
        chk("dio_enable", 0, dio_enable);
        i_host.rd(8'he0, d);
        chk("din_disabled", 0, d);
        i_host.wr(8'hf8, 8'h77);
        chk("dout_disabled", 0, out_line);
        i_host.wr(8'h00, 8'h01);
        chk("dio_enable", 1, dio_enable);
        i_host.wr(8'hf8, 8'ha5);
        i_host.wr(8'hfc, 8'h3c);
        chk("out_line", 16'h3ca5, out_line);
        i_host.rd(8'he0, d);
        chk("din_low", 8'ha5, d);
        i_host.rd(8'he4, d);
        chk("din_high", 8'h5a, d);
        i_host.rd(8'hd4, d);
        chk("ident", 8'h0b, d);
        i_host.wr(8'h00, 8'h00);
        @(negedge clk_sys);
        chk("out_cleared", 0, out_line);
        // Every polarity combination against crossed source levels
        for (int i = 0; i < 4; i++) begin
            irq_source_0 = i[1];
            irq_source_1 = i[0];
            i_host.wr(8'h2a, 8'(i));
            @(negedge clk_sys);
            chk("irq_sel", {i[1] ? i[0] : ~i[0], i[0] ? i[1] : ~i[1]}, {irq_sel_1, irq_sel_0});
        end
        i_host.rd(8'h2a, d);
        chk("polarity_read", 8'h03, d);
        // All six modes, three access formats, both count codings
        for (int i = 0; i < 6; i++) begin
            n = 2'(i % 3);
            i_host.wr(8'hcc, {n, 2'(i % 3 + 1), i[2:0], i[0]});
            chk("timer_cfg", {2'(i % 3 + 1), i[2:0], i[0]}, timer_cfg[6 * n +: 6]);
        end
        i_host.wr(8'hcc, 8'h30);
        i_host.wr(8'hc0, 8'h34);
        i_host.wr(8'hc0, 8'h12);
        chk("reload0", 16'h1234, timer_reload[15:0]);
        chk("timer_load", 3'h1, timer_load);
        i_host.wr(8'hcc, 8'h00);
        i_host.rd(8'hc0, d);
        chk("latch_low", 8'hde, d);
        i_host.rd(8'hc0, d);
        chk("latch_high", 8'hbc, d);
        i_host.rd(8'hc4, d);
        chk("cnt1_high", 8'h78, d);
        i_host.rd(8'hc8, d);
        chk("cnt2_low", 8'h56, d);
        // Read-back latches counter 1; a later count change must not show
        i_host.wr(8'hcc, 8'hc4);
        timer_count = 48'h000000000000;
        i_host.rd(8'hc4, d);
        chk("readback_latch", 8'h78, d);
        i_host.rd(8'hc4, d);
        chk("latch_released", 8'h00, d);
        // Each converter with a distinct word and channel field
        prev_val = 14'h0000;
        for (int k = 0; k < 4; k++) begin
            ch = ~k[1:0];
            val = 14'h2a5c ^ 14'(k * 257);
            i_host.wr(8'hf0, val[7:0]);
            i_host.wr(8'hf4, {ch, val[13:8]});
            chk("no_early_start", {1'b0, prev_val}, {conv_start, analog_word});
            i_host.wr(8'he0 + 8'(4 * k), 8'hff);
            chk("conv_start", 1, conv_start);
            chk("analog_word", val, analog_word);
            chk("analog_channel", {k[1:0], ch}, analog_channel);
            prev_val = val;
        end
        tally_and_finish;
    end
endmodule // daq_card_host_register_file_tb_top

// >>> verif/daq_card_props.sv
// Port-level assertions for the host register file
`timescale 1ns/1ps
module daq_card_props #(
    parameter IDENT_PRESENT = 1
) (
    input wire clk_sys,
    input wire rst,
    input wire [7:0] io_addr,
    input wire io_wr,
    input wire io_rd,
    input wire [7:0] io_wdata,
    input wire [7:0] io_rdata,
    input wire irq_source_0,
    input wire irq_source_1,
    input wire irq_sel_0,
    input wire irq_sel_1,
    input wire [3:0] board_ident,
    input wire [15:0] in_line,
    input wire [15:0] out_line,
    input wire dio_enable,
    input wire [13:0] analog_word,
    input wire [3:0] analog_channel,
    input wire conv_start,
    input wire [17:0] timer_cfg,
    input wire [2:0] timer_cfg_wr,
    input wire [47:0] timer_reload,
    input wire [2:0] timer_load,
    input wire [47:0] timer_count
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    // Converter select writes share e0/e4 with the input reads, so decode on io_wr only
    wire sel_wr = io_wr && io_addr[7:4] == 4'he && io_addr[1:0] == 2'h0;
    // Writes at c0/c4/c8/cc; cc is excluded later by the shifted strobe check
    wire cnt_wr = io_wr && io_addr[7:4] == 4'hc && io_addr[1:0] == 2'h0;

    // ************************************************************
    // Assertions
    // ************************************************************
    conv_pulse_a: assert property (sel_wr |=> conv_start && analog_channel[3:2] == $past(io_addr[3:2]))
        else $error("conversion strobe or converter number wrong");
    conv_cause_a: assert property (conv_start |-> $past(sel_wr))
        else $error("conversion started without a select write");
    dout_low_a: assert property (io_wr && io_addr == 8'hf8 && dio_enable |=>
        out_line[7:0] == $past(io_wdata))
        else $error("output low byte not taken");
    dout_off_a: assert property (!dio_enable ##1 !dio_enable |-> out_line == 16'h0000)
        else $error("outputs driven while disabled");
    din_read_a: assert property (io_rd && io_addr == 8'he0 && dio_enable |=>
        io_rdata == $past(in_line[7:0]))
        else $error("input low byte read wrong");
    ident_read_a: assert property (io_rd && io_addr == 8'hd4 |=>
        io_rdata[7:4] == 4'h0 && (IDENT_PRESENT == 0 || io_rdata[3:0] == $past(board_ident)))
        else $error("identifier read wrong");
    cfg_pulse_a: assert property (io_wr && io_addr == 8'hcc &&
        io_wdata[7:6] != 2'h3 && io_wdata[5:4] != 2'h0 |=> timer_cfg_wr == (3'h1 << $past(io_wdata[7:6])))
        else $error("wrong counter programmed");
    load_cause_a: assert property (timer_load != 3'h0 |->
        $past(cnt_wr) && timer_load == (3'h1 << $past(io_addr[3:2])))
        else $error("reload strobe without a counter data write");
    enable_bit_a: assert property (io_wr && io_addr == 8'h00 |=> dio_enable == $past(io_wdata[0]))
        else $error("enable bit not taken");
    conv_seen_c: cover property (sel_wr ##1 conv_start);
    din_high_c: cover property (io_rd && io_addr == 8'he4 && dio_enable);
    load_seen_c: cover property (timer_load != 3'h0);
endmodule // daq_card_props

bind daq_card_host_register_file daq_card_props #(.IDENT_PRESENT(IDENT_PRESENT)) i_props (.*);

// >>> verif/host_bus_model.sv
// Host side model issuing byte reads and writes on the I/O strobes
`timescale 1ns/1ps
module host_bus_model (
    input wire clk_sys,
    output logic [7:0] io_addr,
    output logic io_wr,
    output logic io_rd,
    output logic [7:0] io_wdata,
    input wire [7:0] io_rdata
);
    // Idle values, all strobes low
    initial begin
        io_addr = 8'h00;
        io_wr = 1'b0;
        io_rd = 1'b0;
        io_wdata = 8'h00;
    end

    // One-cycle write strobe; data inverted on release so stale bytes never look valid
    task wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk_sys);
        io_addr = a;
        io_wdata = d;
        io_wr = 1'b1;
        @(negedge clk_sys);
        io_wr = 1'b0;
        io_wdata = ~d;
    endtask

    // One-cycle read strobe; data is registered at the sampling edge
    task rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge clk_sys);
        io_addr = a;
        io_rd = 1'b1;
        @(negedge clk_sys);
        io_rd = 1'b0;
        io_addr = ~a;
        d = io_rdata;
    endtask
endmodule // host_bus_model
